// File: hw_monitor_alert.sv
// What this block does
// - Monitoring starts only after start bit written
// - Eight channels converted in fixed order
// - Continuous mode restarts the pass immediately
// - Cycle mode idles about one second between passes
// - Cycle mode converts each input once per pass
// - Compare with limits; equality is a violation
// - Readings update only when their conversion ends
// - Status bit sticky; read clears only gone conditions
// - Status registers ignore writes, reset to zero
// - Individual enable blocks setting its status bit
// - Diode open or short sets fault bit
// - Enabled fault loads 80h unless minus-to-ground
// - Fault reaches alert only through 80h reading
// - Remote diode reading 80h forces that zone's fans on
// - Disabled diode: no fault bit, fault loads 00h
// - Config bits route alert onto fan2/tach_in_three pins
// - Global enable gates the alert output
// - Temperature, voltage, fan group enables gate events
// - Alert low while any fully enabled bit set
// - Alert response call releases the alert
// - Alert never active while monitoring stopped
// - Alert response acknowledge clears global enable
// - Special function bit 1 selects cycle mode
// - Temperature 96, voltage 68 conversion clocks
// - Config bit 7 soft reset, self-clearing
`timescale 1ns/1ps
module hw_monitor_alert #(
    parameter int IDLE_TICKS = hw_monitor_pkg::CYCLE_IDLE_TICKS,
    parameter int TICK_DIV   = hw_monitor_pkg::CONV_DIV
) (
    input  wire logic       clock,
    input  wire logic       rst_n,
    input  wire logic [7:0] reg_addr,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata,
    output logic            reg_rdata_valid,
    input  wire logic       ara_ack,
    input  wire logic [7:0] adc_result,
    output logic      [2:0] adc_channel,
    output logic            adc_sample,
    input  wire logic [1:0] diode_fault,
    input  wire logic [1:0] diode_neg_gnd,
    input  wire logic [3:0] tach_fault,
    input  wire logic       fan2_pwm_level,
    output logic            fan_drive_out_two,
    input  wire logic       tach_in_three_i,
    output logic            tach_in_three_o,
    output logic            tach_in_three_oe,
    output logic            tach_three_level,
    output logic            alert_n,
    output logic      [1:0] fan_full_on,
    output logic            monitor_running
);
    // Divider counter is 9 bits wide, so TICK_DIV may not exceed 512
    localparam logic [8:0] DIV_LAST = 9'(TICK_DIV - 1);
    localparam logic [16:0] IDLE_LAST = 17'(IDLE_TICKS - 1);

    reading_mem_if mem ();

    reading_store u_store (
        .clock (clock),
        .rst_n (rst_n),
        .mem   (mem)
    );

    // Conversion clock enable
    logic [8:0] div_ff, nxt_div;
    logic       conv_tick;

    always_comb begin
        conv_tick = (div_ff == DIV_LAST);
        nxt_div   = conv_tick ? 9'h000 : div_ff + 9'h001;
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            div_ff <= 9'h000;
        end else begin
            div_ff <= nxt_div;
        end
    end

    // Registers
    logic       start_ff, nxt_start;
    logic [7:0] sfr_ff, nxt_sfr;
    logic [7:0] volt_en_ff, nxt_volt_en;
    logic [6:0] cfg_ff, nxt_cfg;
    logic [7:0] fan_en_ff, nxt_fan_en;
    logic [7:0] temp_en_ff, nxt_temp_en;
    logic [7:0] st1_ff, nxt_st1;
    logic [7:0] st2_ff, nxt_st2;
    logic [7:0] cond_ff, nxt_cond;
    logic       soft_ff, nxt_soft;
    logic [7:0] lim_lo_ff [8];
    logic [7:0] lim_hi_ff [8];
    logic [7:0] nxt_lim_lo [8];
    logic [7:0] nxt_lim_hi [8];

    // Sequencer
    hw_monitor_pkg::seq_state_type state_ff, nxt_state;
    logic [2:0]  chan_ff, nxt_chan;
    logic [16:0] cnt_ff, nxt_cnt;
    logic        sample_ff, nxt_sample;
    logic [2:0]  sample_chan_ff;
    logic [16:0] step_last;
    logic [16:0] meas;
    logic [2:0]  avg;
    logic        is_temp;

    assign avg     = sfr_ff[hw_monitor_pkg::SFR_AVG_LSB +: 3];
    assign is_temp = hw_monitor_pkg::TEMP_CH_MASK[chan_ff];

    always_comb begin
        if (avg[2]) begin
            meas = 17'd32;
        end else if (avg[1]) begin
            meas = 17'd16;
        end else if (avg[0]) begin
            meas = (is_temp && chan_ff != 3'h1) ? 17'd16 : 17'd1;
        end else begin
            meas = (is_temp && chan_ff != 3'h1) ? 17'd128 : 17'd8;
        end
        step_last = 17'(meas * (is_temp ? 17'(hw_monitor_pkg::TEMP_CONV_CLOCKS)
                                         : 17'(hw_monitor_pkg::VOLT_CONV_CLOCKS)) - 17'd1);
    end

    always_comb begin
        nxt_state  = state_ff;
        nxt_chan   = chan_ff;
        nxt_cnt    = cnt_ff;
        nxt_sample = 1'b0;
        case (state_ff)
            hw_monitor_pkg::SEQ_STOPPED: begin
                if (start_ff) begin
                    nxt_state = hw_monitor_pkg::SEQ_CONVERT;
                    nxt_chan  = 3'h0;
                    nxt_cnt   = 17'h00000;
                end
            end
            hw_monitor_pkg::SEQ_CONVERT: begin
                if (!start_ff) begin
                    nxt_state = hw_monitor_pkg::SEQ_STOPPED;
                end else if (conv_tick) begin
                    if (cnt_ff >= step_last) begin
                        nxt_sample = 1'b1;
                        nxt_cnt    = 17'h00000;
                        // fixed order wraps after step eight
                        nxt_chan   = chan_ff + 3'h1;
                        if (chan_ff == 3'h7 && sfr_ff[hw_monitor_pkg::SFR_MODE_BIT]) begin
                            nxt_state = hw_monitor_pkg::SEQ_IDLE_WAIT;
                        end
                    end else begin
                        nxt_cnt = cnt_ff + 17'h00001;
                    end
                end
            end
            hw_monitor_pkg::SEQ_IDLE_WAIT: begin
                if (!start_ff) begin
                    nxt_state = hw_monitor_pkg::SEQ_STOPPED;
                end else if (conv_tick) begin
                    if (cnt_ff >= IDLE_LAST) begin
                        nxt_state = hw_monitor_pkg::SEQ_CONVERT;
                        nxt_chan  = 3'h0;
                        nxt_cnt   = 17'h00000;
                    end else begin
                        nxt_cnt = cnt_ff + 17'h00001;
                    end
                end
            end
            default: begin
                nxt_state = hw_monitor_pkg::SEQ_STOPPED;
            end
        endcase
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_ff       <= hw_monitor_pkg::SEQ_STOPPED;
            chan_ff        <= 3'h0;
            cnt_ff         <= 17'h00000;
            sample_ff      <= 1'b0;
            sample_chan_ff <= 3'h0;
        end else begin
            state_ff       <= nxt_state;
            chan_ff        <= nxt_chan;
            cnt_ff         <= nxt_cnt;
            sample_ff      <= nxt_sample;
            sample_chan_ff <= chan_ff;
        end
    end

    // Result handling
    logic [7:0] indiv_en;
    logic       diode_sel;
    logic       is_diode;
    logic       diode_on;
    logic       fault_now;
    logic [7:0] value;
    logic       smp_temp;
    logic       violate;
    logic [1:0] diode_on_v;
    logic [7:0] remote_ff [2];
    logic [7:0] nxt_remote [2];

    assign diode_on_v = {temp_en_ff[hw_monitor_pkg::DIODE2_ON_BIT],
                         temp_en_ff[hw_monitor_pkg::DIODE1_ON_BIT]};
    assign indiv_en   = {temp_en_ff[hw_monitor_pkg::TEMP_R2_BIT], volt_en_ff[5:1],
                         temp_en_ff[hw_monitor_pkg::TEMP_AMB_BIT],
                         temp_en_ff[hw_monitor_pkg::TEMP_R1_BIT]};

    always_comb begin
        is_diode  = (sample_chan_ff == hw_monitor_pkg::CH_REMOTE_ONE)
                  || (sample_chan_ff == hw_monitor_pkg::CH_REMOTE_TWO);
        diode_sel = (sample_chan_ff == hw_monitor_pkg::CH_REMOTE_TWO);
        diode_on  = diode_on_v[diode_sel];
        fault_now = is_diode && diode_fault[diode_sel];
        value     = adc_result;
        // disabled diode reads zero on fault
        if (fault_now) begin
            if (!diode_on) begin
                value = hw_monitor_pkg::OFF_READING;
            end else if (!diode_neg_gnd[diode_sel]) begin
                value = hw_monitor_pkg::FAULT_READING;
            end
        end
        smp_temp = hw_monitor_pkg::TEMP_CH_MASK[sample_chan_ff];
        // 80h is at or below any signed low limit
        if (smp_temp) begin
            violate = ($signed(value) <= $signed(lim_lo_ff[sample_chan_ff]))
                   || ($signed(value) >= $signed(lim_hi_ff[sample_chan_ff]));
        end else begin
            violate = (value <= lim_lo_ff[sample_chan_ff])
                   || (value >= lim_hi_ff[sample_chan_ff]);
        end
    end

    // reading written once at conversion end
    assign mem.wr_en   = sample_ff;
    assign mem.wr_idx  = sample_chan_ff;
    assign mem.wr_data = value;
    assign mem.rd_idx  = reg_addr[2:0];

    // Register access and status
    logic [7:0] local_val;
    logic [7:0] st1_set;
    logic [7:0] st2_set;
    logic [7:0] st2_live;
    logic       lim_hit;
    logic [3:0] lim_idx;
    logic       rd_pend_ff;
    logic       rd_mem_ff;
    logic [7:0] rd_local_ff;

    assign lim_hit = (reg_addr >= hw_monitor_pkg::ADDR_LIMIT_BASE)
                  && (reg_addr <= hw_monitor_pkg::ADDR_LIMIT_LAST);
    assign lim_idx = 4'(reg_addr - hw_monitor_pkg::ADDR_LIMIT_BASE);

    always_comb begin
        nxt_start   = start_ff;
        nxt_sfr     = sfr_ff;
        nxt_volt_en = volt_en_ff;
        nxt_cfg     = cfg_ff;
        nxt_fan_en  = fan_en_ff;
        nxt_temp_en = temp_en_ff;
        nxt_soft    = 1'b0;
        nxt_cond    = cond_ff;
        nxt_remote  = remote_ff;
        nxt_lim_lo  = lim_lo_ff;
        nxt_lim_hi  = lim_hi_ff;
        st1_set     = 8'h00;
        st2_set     = 8'h00;
        // fault kinds all set the bit
        st2_live    = {2'b00, tach_fault & fan_en_ff[4:1],
                       diode_fault & diode_on_v};
        if (sample_ff) begin
            nxt_cond[sample_chan_ff] = violate;
            st1_set[sample_chan_ff]  = violate && indiv_en[sample_chan_ff];
            if (is_diode) begin
                nxt_remote[diode_sel] = value;
                st2_set[diode_sel] = fault_now && diode_on;
            end
        end
        st2_set[hw_monitor_pkg::ST2_FAN_LSB +: 4] = st2_live[hw_monitor_pkg::ST2_FAN_LSB +: 4];
        // read clears only gone conditions, set wins
        nxt_st1 = st1_ff | st1_set;
        nxt_st2 = st2_ff | st2_set;
        if (reg_rd && reg_addr == hw_monitor_pkg::ADDR_STATUS_ONE) begin
            nxt_st1 = st1_set | (st1_ff & cond_ff);
        end
        if (reg_rd && reg_addr == hw_monitor_pkg::ADDR_STATUS_TWO) begin
            nxt_st2 = st2_set | (st2_ff & st2_live);
        end
        if (reg_wr) begin
            case (reg_addr)
                hw_monitor_pkg::ADDR_START:   nxt_start   = reg_wdata[hw_monitor_pkg::START_BIT];
                hw_monitor_pkg::ADDR_SFR:     nxt_sfr     = reg_wdata;
                hw_monitor_pkg::ADDR_VOLT_EN: nxt_volt_en = reg_wdata;
                hw_monitor_pkg::ADDR_FAN_EN:  nxt_fan_en  = reg_wdata;
                hw_monitor_pkg::ADDR_TEMP_EN: nxt_temp_en = reg_wdata;
                hw_monitor_pkg::ADDR_CONFIG: begin
                    nxt_cfg  = reg_wdata[6:0];
                    nxt_soft = reg_wdata[hw_monitor_pkg::CFG_SOFT_BIT];
                end
                default: begin
                    if (lim_hit) begin
                        if (lim_idx[0]) begin
                            nxt_lim_hi[lim_idx[3:1]] = reg_wdata;
                        end else begin
                            nxt_lim_lo[lim_idx[3:1]] = reg_wdata;
                        end
                    end
                end
            endcase
        end
        // acknowledge drops global enable; a same-cycle write wins
        if (ara_ack && !(reg_wr && reg_addr == hw_monitor_pkg::ADDR_SFR)) begin
            nxt_sfr[hw_monitor_pkg::SFR_ALERT_GLOBAL_GATE_BIT] = 1'b0;
        end
        case (reg_addr)
            hw_monitor_pkg::ADDR_START:      local_val = {7'h00, start_ff};
            hw_monitor_pkg::ADDR_STATUS_ONE: local_val = st1_ff;
            hw_monitor_pkg::ADDR_STATUS_TWO: local_val = st2_ff;
            hw_monitor_pkg::ADDR_SFR:        local_val = sfr_ff;
            hw_monitor_pkg::ADDR_VOLT_EN:    local_val = volt_en_ff;
            hw_monitor_pkg::ADDR_CONFIG:     local_val = {1'b0, cfg_ff};
            hw_monitor_pkg::ADDR_FAN_EN:     local_val = fan_en_ff;
            hw_monitor_pkg::ADDR_TEMP_EN:    local_val = temp_en_ff;
            default: begin
                if (lim_hit) begin
                    local_val = lim_idx[0] ? lim_hi_ff[lim_idx[3:1]] : lim_lo_ff[lim_idx[3:1]];
                end else begin
                    local_val = 8'h00;
                end
            end
        endcase
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n || soft_ff) begin
            start_ff   <= 1'b0;
            sfr_ff     <= hw_monitor_pkg::SFR_RESET;
            volt_en_ff <= hw_monitor_pkg::REG_ZERO;
            cfg_ff     <= 7'h00;
            fan_en_ff  <= hw_monitor_pkg::REG_ZERO;
            temp_en_ff <= hw_monitor_pkg::TEMP_EN_RESET;
            st1_ff     <= hw_monitor_pkg::REG_ZERO;
            st2_ff     <= hw_monitor_pkg::REG_ZERO;
            cond_ff    <= 8'h00;
            soft_ff    <= 1'b0;
            for (int i = 0; i < hw_monitor_pkg::CHANNELS; i++) begin
                lim_lo_ff[i] <= hw_monitor_pkg::LIMIT_LOW_RESET;
                lim_hi_ff[i] <= hw_monitor_pkg::LIMIT_HI_RESET;
            end
        end else begin
            start_ff   <= nxt_start;
            sfr_ff     <= nxt_sfr;
            volt_en_ff <= nxt_volt_en;
            cfg_ff     <= nxt_cfg;
            fan_en_ff  <= nxt_fan_en;
            temp_en_ff <= nxt_temp_en;
            st1_ff     <= nxt_st1;
            st2_ff     <= nxt_st2;
            cond_ff    <= nxt_cond;
            soft_ff    <= nxt_soft;
            lim_lo_ff  <= nxt_lim_lo;
            lim_hi_ff  <= nxt_lim_hi;
        end
    end

    // Remote copies follow the reading store and are not soft reset
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            remote_ff[0] <= 8'h00;
            remote_ff[1] <= 8'h00;
        end else begin
            remote_ff <= nxt_remote;
        end
    end

    // Read path: two cycles, status captured before its clear lands
    logic [7:0] nxt_rdata;

    always_comb begin
        nxt_rdata = rd_mem_ff ? mem.rd_data : rd_local_ff;
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rd_pend_ff      <= 1'b0;
            rd_mem_ff       <= 1'b0;
            rd_local_ff     <= 8'h00;
            reg_rdata       <= 8'h00;
            reg_rdata_valid <= 1'b0;
        end else begin
            rd_pend_ff      <= reg_rd;
            rd_mem_ff       <= (reg_addr[7:3] == hw_monitor_pkg::ADDR_READING_BASE[7:3]);
            rd_local_ff     <= local_val;
            reg_rdata       <= rd_pend_ff ? nxt_rdata : reg_rdata;
            reg_rdata_valid <= rd_pend_ff;
        end
    end

    // Alert path
    logic       running;
    logic       alert_want;
    logic [7:0] st1_gated;

    always_comb begin
        running   = (state_ff != hw_monitor_pkg::SEQ_STOPPED);
        st1_gated = st1_ff & indiv_en;
        // any fully enabled bit holds alert
        alert_want = sfr_ff[hw_monitor_pkg::SFR_ALERT_GLOBAL_GATE_BIT] && running
            && ((temp_en_ff[hw_monitor_pkg::GROUP_EN_BIT]
                    && |(st1_gated & hw_monitor_pkg::TEMP_CH_MASK))
             || (volt_en_ff[hw_monitor_pkg::GROUP_EN_BIT]
                    && |(st1_gated & hw_monitor_pkg::VOLT_CH_MASK))
             || (fan_en_ff[hw_monitor_pkg::GROUP_EN_BIT]
                    && |(st2_ff[hw_monitor_pkg::ST2_FAN_LSB +: 4] & fan_en_ff[4:1])));
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            alert_n           <= 1'b1;
            fan_drive_out_two <= 1'b0;
            tach_in_three_o   <= 1'b0;
            tach_in_three_oe  <= 1'b0;
            tach_three_level  <= 1'b0;
            fan_full_on       <= 2'b00;
            monitor_running   <= 1'b0;
            adc_channel       <= 3'h0;
            adc_sample        <= 1'b0;
        end else begin
            alert_n           <= !alert_want;
            fan_drive_out_two <= cfg_ff[hw_monitor_pkg::CFG_FAN2_BIT] ? !alert_want
                                                                       : fan2_pwm_level;
            tach_in_three_o   <= 1'b0;
            tach_in_three_oe  <= cfg_ff[hw_monitor_pkg::CFG_TACH_IN_THREE_BIT] && alert_want;
            tach_three_level  <= tach_in_three_i;
            fan_full_on[0]    <= (remote_ff[0] == hw_monitor_pkg::FAULT_READING);
            fan_full_on[1]    <= (remote_ff[1] == hw_monitor_pkg::FAULT_READING);
            monitor_running   <= running;
            adc_channel       <= chan_ff;
            adc_sample        <= nxt_sample;
        end
    end
endmodule

// File: hw_monitor_pkg.sv
package hw_monitor_pkg;

    localparam int DATA_W   = 8;
    localparam int ADDR_W   = 8;
    localparam int CHANNELS = 8;
    localparam int CHAN_W   = 3;
    localparam int CNT_W    = 17;

    // Register offsets
    localparam logic [7:0] ADDR_READING_BASE = 8'h20;
    localparam logic [7:0] ADDR_START        = 8'h40;
    localparam logic [7:0] ADDR_STATUS_ONE   = 8'h41;
    localparam logic [7:0] ADDR_STATUS_TWO   = 8'h42;
    localparam logic [7:0] ADDR_LIMIT_BASE   = 8'h44;
    localparam logic [7:0] ADDR_LIMIT_LAST   = 8'h53;
    localparam logic [7:0] ADDR_SFR          = 8'h7C;
    localparam logic [7:0] ADDR_VOLT_EN      = 8'h7E;
    localparam logic [7:0] ADDR_CONFIG       = 8'h7F;
    localparam logic [7:0] ADDR_FAN_EN       = 8'h80;
    localparam logic [7:0] ADDR_TEMP_EN      = 8'h82;

    // Field positions
    localparam int START_BIT     = 0;
    localparam int SFR_MODE_BIT  = 1;
    localparam int SFR_ALERT_GLOBAL_GATE_BIT = 2;
    localparam int SFR_AVG_LSB   = 5;
    localparam int CFG_TACH_IN_THREE_BIT = 0;
    localparam int CFG_FAN2_BIT  = 1;
    localparam int CFG_SOFT_BIT  = 7;
    localparam int GROUP_EN_BIT  = 0;
    localparam int TEMP_R1_BIT   = 1;
    localparam int TEMP_AMB_BIT  = 2;
    localparam int TEMP_R2_BIT   = 3;
    localparam int DIODE1_ON_BIT = 4;
    localparam int DIODE2_ON_BIT = 5;
    localparam int ST2_FAN_LSB   = 2;

    // Reset values and fault readings
    localparam logic [7:0] SFR_RESET       = 8'h40;
    localparam logic [7:0] TEMP_EN_RESET   = 8'h30;
    localparam logic [7:0] REG_ZERO        = 8'h00;
    localparam logic [7:0] LIMIT_LOW_RESET = 8'h00;
    localparam logic [7:0] LIMIT_HI_RESET  = 8'hFF;
    localparam logic [7:0] FAULT_READING   = 8'h80;
    localparam logic [7:0] OFF_READING     = 8'h00;

    // Channel order and classes
    localparam logic [2:0] CH_REMOTE_ONE = 3'h0;
    localparam logic [2:0] CH_REMOTE_TWO = 3'h7;
    localparam logic [7:0] TEMP_CH_MASK  = 8'h83;
    localparam logic [7:0] VOLT_CH_MASK  = 8'h7C;

    // Timing
    localparam int CLK_HZ           = 20_000_000;
    localparam int CONV_CLK_HZ      = 45_000;
    localparam int CONV_DIV         = CLK_HZ / CONV_CLK_HZ;
    localparam int TEMP_CONV_CLOCKS = 96;
    localparam int VOLT_CONV_CLOCKS = 68;
    localparam int CYCLE_IDLE_MS    = 1000;
    localparam int CYCLE_IDLE_TICKS = CYCLE_IDLE_MS * (CONV_CLK_HZ / 1000);

    typedef enum logic [1:0] {SEQ_STOPPED, SEQ_CONVERT, SEQ_IDLE_WAIT} seq_state_type;

endpackage

// File: reading_mem_if.sv
`timescale 1ns/1ps
interface reading_mem_if;
    logic       wr_en;
    logic [2:0] wr_idx;
    logic [7:0] wr_data;
    logic [2:0] rd_idx;
    logic [7:0] rd_data;

    modport writer (output wr_en, output wr_idx, output wr_data, output rd_idx, input rd_data);
    modport store  (input wr_en, input wr_idx, input wr_data, input rd_idx, output rd_data);
endinterface

// File: reading_store.sv
`timescale 1ns/1ps
module reading_store (
    input  wire logic           clock,
    input  wire logic           rst_n,
    reading_mem_if.store        mem
);
    // Readings have no reset value; only the read port is cleared
    logic [7:0] word_ff [hw_monitor_pkg::CHANNELS];
    logic [7:0] rd_data_ff;

    always_ff @(posedge clock) begin
        if (mem.wr_en) begin
            word_ff[mem.wr_idx] <= mem.wr_data;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rd_data_ff <= 8'h00;
        end else begin
            rd_data_ff <= word_ff[mem.rd_idx];
        end
    end

    assign mem.rd_data = rd_data_ff;
endmodule

// File: hw_host_model.sv
`timescale 1ns/1ps
module hw_host_model (
    input  wire logic       clock,
    output logic      [7:0] reg_addr,
    output logic            reg_wr,
    output logic            reg_rd,
    output logic      [7:0] reg_wdata,
    output logic            ara_ack,
    input  wire logic [7:0] reg_rdata,
    input  wire logic       reg_rdata_valid
);
    initial {reg_addr, reg_wr, reg_rd, reg_wdata, ara_ack} = '0;
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'h1;
        @(posedge clock);
        reg_wr    <= 1'h0;
        // Released lines flip so stale values never look valid
        reg_addr  <= ~a;
        reg_wdata <= ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_rd   <= 1'h1;
        @(posedge clock);
        reg_rd   <= 1'h0;
        // Data is taken at the edge where valid is seen high
        do begin
            @(posedge clock);
        end while (reg_rdata_valid !== 1'h1);
        d = reg_rdata;
    endtask
    task automatic ara;
        @(posedge clock);
        ara_ack <= 1'h1;
        @(posedge clock);
        ara_ack <= 1'h0;
    endtask
endmodule

// File: hw_monitor_alert_asserts.sv
`timescale 1ns/1ps
module hw_monitor_alert_asserts (
    input wire logic       clock,
    input wire logic       rst_n,
    input wire logic       reg_rd,
    input wire logic       reg_wr,
    input wire logic       reg_rdata_valid,
    input wire logic       ara_ack,
    input wire logic       alert_n,
    input wire logic       monitor_running,
    input wire logic       adc_sample,
    input wire logic [2:0] adc_channel,
    input wire logic       tach_in_three_o
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    a_read_answer: assert property (reg_rd |-> ##2 reg_rdata_valid)
        else $error("read answer late");
    a_valid_cause: assert property (reg_rdata_valid |-> $past(reg_rd, 2))
        else $error("read answer without strobe");
    a_stop_quiet: assert property (!monitor_running |-> alert_n)
        else $error("alert while stopped");
    a_ara_release: assert property (ara_ack && !reg_wr ##1 !reg_wr |-> ##1 alert_n)
        else $error("alert kept after response");
    a_sample_gap: assert property (adc_sample |=> !adc_sample [*8])
        else $error("steps too short");
    a_sample_running: assert property (adc_sample |-> monitor_running)
        else $error("sample while stopped");
    a_chan_order: assert property ($changed(adc_channel) && $past(monitor_running)
        && monitor_running |-> adc_channel == $past(adc_channel) + 3'h1)
        else $error("channel order broken");
    a_tach_drain: assert property (!tach_in_three_o)
        else $error("open drain drives high");
endmodule
bind hw_monitor_alert hw_monitor_alert_asserts chk_u (.*);

// File: test_hw_monitor_alert.sv
`timescale 1ns/1ps
module test_hw_monitor_alert;
    logic clock = 1'h0, rst_n = 1'h0, fan2_pwm_level = 1'h1;
    logic reg_wr, reg_rd, ara_ack, reg_rdata_valid, adc_sample, monitor_running, alert_n;
    logic fan_drive_out_two, tach_in_three_o, tach_in_three_oe, tach_three_level;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, rv, adc_result = 8'h19;
    logic [2:0] adc_channel;
    logic [1:0] diode_fault = 2'h0, diode_neg_gnd = 2'h0, fan_full_on;
    logic [3:0] tach_fault = 4'h0;
    int fail_count = 0, n_compared = 0, cycles = 0, n;
    localparam int DIV = 4;
    // Pull-up on the shared tach pin
    wire tach_in_three_i = tach_in_three_oe ? tach_in_three_o : 1'h1;
    hw_monitor_alert #(.IDLE_TICKS(4), .TICK_DIV(DIV)) dut_u (.*);
    hw_host_model host_u (.*);
    initial forever #25 clock = ~clock;
    always @(posedge clock) if (++cycles == 20000) begin
        fail_count++;
        final_report();
    end
    task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        host_u.rd(a, rv);
        chk($sformatf("reg %h", a), e, rv);
    endtask
    task automatic wait_sample(input int t);
        for (n = 0; n < 7000 && adc_sample !== 1'h1; n++) @(negedge clock);
        chk("step length", 1, 8'(n > t - 100 && n < t + 100));
        repeat (3) @(negedge clock);
    endtask
    task automatic final_report;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge clock);
        rst_n <= 1'h1;
        host_u.wr(8'h41, 8'hFF);
        rchk(8'h41, 8'h00);
        rchk(8'h7C, 8'h40);
        rchk(8'h82, 8'h30);
        rchk(8'h10, 8'h00);
        chk("running", 0, 8'(monitor_running));
        $display("test reset values done");
        host_u.wr(8'h82, 8'h33);
        host_u.wr(8'h7C, 8'h44);
        host_u.wr(8'h7F, 8'h02);
        diode_fault <= 2'h1;
        host_u.wr(8'h40, 8'h01);
        wait_sample(16 * hw_monitor_pkg::TEMP_CONV_CLOCKS * DIV);
        rchk(8'h20, 8'h80);
        chk("fan full", 8'h01, 8'(fan_full_on));
        chk("alert", 0, 8'(alert_n));
        chk("fan2 pin", 0, 8'(fan_drive_out_two));
        chk("tach_in_three oe", 0, 8'(tach_in_three_oe));
        chk("tach_in_three level", 1, 8'(tach_three_level));
        rchk(8'h42, 8'h01);
        rchk(8'h41, 8'h01);
        rchk(8'h41, 8'h01);
        host_u.ara();
        repeat (3) @(posedge clock);
        chk("alert", 1, 8'(alert_n));
        rchk(8'h7C, 8'h40);
        $display("test diode fault done");
        diode_fault <= 2'h0;
        wait_sample(16 * hw_monitor_pkg::TEMP_CONV_CLOCKS * DIV);
        chk("channel", 2, 8'(adc_channel));
        rchk(8'h21, 8'h19);
        rchk(8'h41, 8'h01);
        host_u.wr(8'h7C, 8'h44);
        repeat (3) @(negedge clock);
        chk("alert", 0, 8'(alert_n));
        host_u.wr(8'h40, 8'h00);
        repeat (3) @(negedge clock);
        chk("running", 0, 8'(monitor_running));
        chk("alert", 1, 8'(alert_n));
        host_u.wr(8'h7F, 8'h80);
        repeat (2) @(posedge clock);
        rchk(8'h82, 8'h30);
        rchk(8'h20, 8'h80);
        rchk(8'h41, 8'h00);
        chk("fan2 pin", 1, 8'(fan_drive_out_two));
        $display("test stop and soft reset done");
        final_report();
    end
endmodule
